// File: verilog/aasf_pkg.sv
package aasf_pkg;
   // register offsets in the control map
   localparam logic [7:0] ADDR_PCM_RATE   = 8'h2f;
   localparam logic [7:0] ADDR_CLK_RECOV  = 8'h32;
   localparam logic [7:0] ADDR_DEBUG      = 8'h35;
   localparam logic [7:0] ADDR_PWR_STATE  = 8'h64;
   localparam logic [7:0] ADDR_BOOT_STATE = 8'h65;
   localparam logic [7:0] ADDR_FAULT      = 8'h68;

   // reset values
   localparam logic [7:0] RST_PCM_RATE  = 8'h00;
   localparam logic [7:0] RST_CLK_RECOV = 8'h00;
   localparam logic [7:0] RST_DEBUG     = 8'h00;
   localparam logic [7:0] RST_FAULT     = 8'h00;

   // field positions
   localparam int PCM_RATE_LSB     = 0;
   localparam int RECOV_DET1_BIT   = 0;
   localparam int RECOV_DET2_BIT   = 1;
   localparam int DPU_FORCE_BIT    = 2;
   localparam int PWR_STATE_LSB    = 2;
   localparam int BOOT_BUSY_BIT    = 2;
   localparam int FLT_OVERCUR_BIT  = 7;
   localparam int FLT_UNDERV_BIT   = 6;
   localparam int FLT_OVERTEMP_BIT = 4;
   localparam int FLT_BROWNOUT_BIT = 3;
   localparam int FLT_CLKLOST_BIT  = 2;
   localparam int FLT_SARDONE_BIT  = 1;

   // pcm input sample rate codes
   typedef enum logic [1:0] {
      AASF_RATE_8K,
      AASF_RATE_16K,
      AASF_RATE_48K,
      AASF_RATE_96K
   } aasf_rate_t;

   // clock-error timeouts, in microseconds, per 3-bit code
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned TIMEOUT_US [8] = '{2730, 22000, 44000, 87000,
                                              174000, 350000, 700000, 1400000};
   localparam int CNT_W = 26;

   // longest time rounds down to whole cycles
   function automatic logic [CNT_W-1:0] us_to_cycles(input int unsigned us);
      int unsigned c;
      c = (us * 32'd1000) / CLK_PERIOD_NS;
      return c[CNT_W-1:0];
   endfunction

   localparam logic [7:0][CNT_W-1:0] TIMEOUT_CYC = {
      us_to_cycles(TIMEOUT_US[7]), us_to_cycles(TIMEOUT_US[6]),
      us_to_cycles(TIMEOUT_US[5]), us_to_cycles(TIMEOUT_US[4]),
      us_to_cycles(TIMEOUT_US[3]), us_to_cycles(TIMEOUT_US[2]),
      us_to_cycles(TIMEOUT_US[1]), us_to_cycles(TIMEOUT_US[0])};

   // live power indications, msb = converter
   typedef struct packed {
      logic converter_powered;
      logic output_stage_powered;
      logic booster_powered;
      logic booster_passthrough_on;
      logic current_sense_powered;
      logic voltage_sense_powered;
   } aasf_power_t;

   // fault and event sources, level while the condition holds
   typedef struct packed {
      logic overcurrent;
      logic undervoltage;
      logic overtemp;
      logic brownout;
      logic sar_done;
   } aasf_events_t;
endpackage

// File: verilog/aasf_clk_err_det.sv
`timescale 1ns/1ps
module aasf_clk_err_det #(
   parameter int                                    CNT_W  = aasf_pkg::CNT_W,
   parameter logic [7:0][CNT_W-1:0]                 LIMITS = aasf_pkg::TIMEOUT_CYC
) (
   input  wire logic       clk_i,
   input  wire logic       arst_n_i,
   input  wire logic       enable_i,
   input  wire logic       recovery_off_i,
   input  wire logic [2:0] timeout_sel_i,
   input  wire logic       mon_clk_i,
   output logic            error_o,
   output logic            error_set_o
);
   logic             sync1;
   logic             sync2;
   logic             sync3;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic             next_error;
   logic             next_error_set;
   logic             activity;
   logic [CNT_W-1:0] limit;

   // monitored clock is foreign: two flops before any logic looks at it
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
      end
      else
      begin
         sync1 <= mon_clk_i;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   assign activity = sync2 ^ sync3;
   assign limit    = LIMITS[timeout_sel_i];

   // silence counter and error level
   always_comb
   begin
      next_cnt       = cnt;
      next_error     = error_o;
      next_error_set = 1'b0;
      if (!enable_i || activity)
         next_cnt = '0;
      else if (cnt != limit)
         next_cnt = cnt + 1'b1;
      if (!enable_i)
         next_error = 1'b0;
      else if (!error_o && cnt == limit)
      begin
         next_error     = 1'b1;
         next_error_set = 1'b1;
      end
      else if (error_o && activity && !recovery_off_i)
         next_error = 1'b0;
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cnt         <= '0;
         error_o     <= 1'b0;
         error_set_o <= 1'b0;
      end
      else
      begin
         cnt         <= next_cnt;
         error_o     <= next_error;
         error_set_o <= next_error_set;
      end
   end

   AST_TIMEOUT_TRIPS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      enable_i && !error_o && cnt == limit |=> error_o && error_set_o)
      else $error("silence past timeout did not raise the error");

   AST_NO_RECOVERY: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      error_o && enable_i && recovery_off_i |=> error_o)
      else $error("error cleared although recovery is disabled");
endmodule

// File: verilog/aasf_regs.sv
`timescale 1ns/1ps
module aasf_regs #(
   parameter logic [7:0][aasf_pkg::CNT_W-1:0] TIMEOUT_CYC = aasf_pkg::TIMEOUT_CYC
) (
   input  wire logic                   clk_i,
   input  wire logic                   arst_n_i,
   input  wire logic                   reg_wr_i,
   input  wire logic                   reg_rd_i,
   input  wire logic [7:0]             reg_addr_i,
   input  wire logic [7:0]             reg_wdata_i,
   input  wire aasf_pkg::aasf_power_t  power_state_i,
   input  wire logic                   processor_boot_busy_i,
   input  wire aasf_pkg::aasf_events_t fault_event_i,
   input  wire logic                   det1_enable_i,
   input  wire logic                   det2_enable_i,
   input  wire logic [2:0]             det1_timeout_i,
   input  wire logic [2:0]             det2_timeout_i,
   input  wire logic                   det1_clk_i,
   input  wire logic                   det2_clk_i,
   output logic [7:0]                  reg_rdata_o,
   output aasf_pkg::aasf_rate_t        pcm_rate_code_o,
   output logic                        detector_one_recovery_off_o,
   output logic                        detector_two_recovery_off_o,
   output logic                        dummy_powerup_force_down_o,
   output logic                        power_error_o
);
   logic [7:0] pcm_rate;
   logic [7:0] clk_recov;
   logic [7:0] debug_ovr;
   logic [7:0] fault_latch;
   logic [7:0] next_pcm_rate;
   logic [7:0] next_clk_recov;
   logic [7:0] next_debug_ovr;
   logic [7:0] next_fault_latch;
   logic [7:0] next_rdata;
   logic [7:0] fault_set;
   logic       next_power_error;
   logic       det1_err;
   logic       det2_err;
   logic       det1_set;
   logic       det2_set;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      return a == b;
   endfunction

   // the two clock-error detectors
   aasf_clk_err_det #(.CNT_W(aasf_pkg::CNT_W), .LIMITS(TIMEOUT_CYC)) u_det1 (
      .clk_i          (clk_i),
      .arst_n_i       (arst_n_i),
      .enable_i       (det1_enable_i),
      .recovery_off_i (clk_recov[aasf_pkg::RECOV_DET1_BIT]),
      .timeout_sel_i  (det1_timeout_i),
      .mon_clk_i      (det1_clk_i),
      .error_o        (det1_err),
      .error_set_o    (det1_set)
   );

   aasf_clk_err_det #(.CNT_W(aasf_pkg::CNT_W), .LIMITS(TIMEOUT_CYC)) u_det2 (
      .clk_i          (clk_i),
      .arst_n_i       (arst_n_i),
      .enable_i       (det2_enable_i),
      .recovery_off_i (clk_recov[aasf_pkg::RECOV_DET2_BIT]),
      .timeout_sel_i  (det2_timeout_i),
      .mon_clk_i      (det2_clk_i),
      .error_o        (det2_err),
      .error_set_o    (det2_set)
   );

   // event sources mapped to their flag positions
   always_comb
   begin
      fault_set = 8'h00;
      fault_set[aasf_pkg::FLT_OVERCUR_BIT]  = fault_event_i.overcurrent;
      fault_set[aasf_pkg::FLT_UNDERV_BIT]   = fault_event_i.undervoltage;
      fault_set[aasf_pkg::FLT_OVERTEMP_BIT] = fault_event_i.overtemp;
      fault_set[aasf_pkg::FLT_BROWNOUT_BIT] = fault_event_i.brownout;
      fault_set[aasf_pkg::FLT_CLKLOST_BIT]  = det1_set | det2_set;
      fault_set[aasf_pkg::FLT_SARDONE_BIT]  = fault_event_i.sar_done;
   end

   // writable fields, only defined bits are stored
   always_comb
   begin
      next_pcm_rate  = pcm_rate;
      next_clk_recov = clk_recov;
      next_debug_ovr = debug_ovr;
      if (reg_wr_i && hit(reg_addr_i, aasf_pkg::ADDR_PCM_RATE))
         next_pcm_rate = {6'h00, reg_wdata_i[aasf_pkg::PCM_RATE_LSB +: 2]};
      if (reg_wr_i && hit(reg_addr_i, aasf_pkg::ADDR_CLK_RECOV))
         next_clk_recov = {6'h00, reg_wdata_i[1:0]};
      if (reg_wr_i && hit(reg_addr_i, aasf_pkg::ADDR_DEBUG))
         next_debug_ovr = {5'h00, reg_wdata_i[aasf_pkg::DPU_FORCE_BIT], 2'h0};
   end

   // sticky flags: a set in the clearing cycle wins
   always_comb
   begin
      next_fault_latch = fault_latch;
      if (reg_rd_i && hit(reg_addr_i, aasf_pkg::ADDR_FAULT))
         next_fault_latch = 8'h00;
      next_fault_latch = next_fault_latch | fault_set;
   end

   // read mux; unmapped addresses read zero
   always_comb
   begin
      next_rdata = reg_rdata_o;
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            aasf_pkg::ADDR_PCM_RATE:   next_rdata = pcm_rate;
            aasf_pkg::ADDR_CLK_RECOV:  next_rdata = clk_recov;
            aasf_pkg::ADDR_DEBUG:      next_rdata = debug_ovr;
            aasf_pkg::ADDR_PWR_STATE:  next_rdata = {power_state_i, 2'b00};
            aasf_pkg::ADDR_BOOT_STATE:
               next_rdata = {5'h00, processor_boot_busy_i, 2'b00};
            aasf_pkg::ADDR_FAULT:      next_rdata = fault_latch;
            default:                   next_rdata = 8'h00;
         endcase
      end
   end

   // either detector in error shuts the device down
   assign next_power_error = det1_err | det2_err;

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         pcm_rate      <= aasf_pkg::RST_PCM_RATE;
         clk_recov     <= aasf_pkg::RST_CLK_RECOV;
         debug_ovr     <= aasf_pkg::RST_DEBUG;
         fault_latch   <= aasf_pkg::RST_FAULT;
         reg_rdata_o   <= 8'h00;
         power_error_o <= 1'b0;
      end
      else
      begin
         pcm_rate      <= next_pcm_rate;
         clk_recov     <= next_clk_recov;
         debug_ovr     <= next_debug_ovr;
         fault_latch   <= next_fault_latch;
         reg_rdata_o   <= next_rdata;
         power_error_o <= next_power_error;
      end
   end

   // control outputs are own flops loaded from the same next values, in step with the register flops
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         pcm_rate_code_o             <= aasf_pkg::AASF_RATE_8K;
         detector_one_recovery_off_o <= 1'b0;
         detector_two_recovery_off_o <= 1'b0;
         dummy_powerup_force_down_o  <= 1'b0;
      end
      else
      begin
         pcm_rate_code_o             <= aasf_pkg::aasf_rate_t'(next_pcm_rate[1:0]);
         detector_one_recovery_off_o <= next_clk_recov[aasf_pkg::RECOV_DET1_BIT];
         detector_two_recovery_off_o <= next_clk_recov[aasf_pkg::RECOV_DET2_BIT];
         dummy_powerup_force_down_o  <= next_debug_ovr[aasf_pkg::DPU_FORCE_BIT];
      end
   end

   AST_RATE_WRITE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      reg_wr_i && reg_addr_i == aasf_pkg::ADDR_PCM_RATE
      |=> pcm_rate_code_o == $past(reg_wdata_i[1:0]))
      else $error("pcm rate code does not follow the write");

   AST_RECOV_WRITE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      reg_wr_i && reg_addr_i == aasf_pkg::ADDR_CLK_RECOV
      |=> detector_one_recovery_off_o == $past(reg_wdata_i[0])
          && detector_two_recovery_off_o == $past(reg_wdata_i[1]))
      else $error("recovery bits do not follow the write");

   AST_FORCE_DOWN: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      reg_wr_i && reg_addr_i == aasf_pkg::ADDR_DEBUG
      |=> dummy_powerup_force_down_o == $past(reg_wdata_i[2]))
      else $error("force-down override does not follow the write");

   AST_POWER_READ: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      reg_rd_i && reg_addr_i == aasf_pkg::ADDR_PWR_STATE
      |=> reg_rdata_o == {$past(power_state_i), 2'b00})
      else $error("power state read is not the live state");

   AST_BOOT_READ: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      reg_rd_i && reg_addr_i == aasf_pkg::ADDR_BOOT_STATE
      |=> reg_rdata_o == {5'h00, $past(processor_boot_busy_i), 2'b00})
      else $error("boot state read is wrong");

   AST_READ_CLEARS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      reg_rd_i && reg_addr_i == aasf_pkg::ADDR_FAULT && fault_set == 8'h00
      |=> fault_latch == 8'h00 && reg_rdata_o == $past(fault_latch))
      else $error("fault read did not return and clear the flags");

   AST_OVERCUR_STICKY: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      fault_event_i.overcurrent ##1 !(reg_rd_i && reg_addr_i == aasf_pkg::ADDR_FAULT)
      |=> fault_latch[7])
      else $error("overcurrent flag not held until read");

   AST_SAR_SET: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      fault_event_i.sar_done |=> fault_latch[1])
      else $error("sar done flag not set");

   AST_SET_WINS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      reg_rd_i && reg_addr_i == aasf_pkg::ADDR_FAULT && fault_event_i.brownout
      |=> fault_latch[3])
      else $error("brownout lost during a clearing read");

   AST_POWER_ERROR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      $rose(det1_err) |=> power_error_o)
      else $error("power error did not follow a detector error");

   AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      reg_rd_i && reg_addr_i == aasf_pkg::ADDR_PCM_RATE |=> reg_rdata_o[7:2] == 6'h00)
      else $error("reserved bits read non-zero");
endmodule

// File: bench/aasf_host_model.sv
`timescale 1ns/1ps
// host side of the register port, strobes are one-cycle pulses
module aasf_host_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] reg_rdata_i,
   output logic            reg_wr_o,
   output logic            reg_rd_o,
   output logic [7:0]      reg_addr_o,
   output logic [7:0]      reg_wdata_o
);
   initial
   begin
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      reg_addr_o  = 8'h00;
      reg_wdata_o = 8'h00;
   end

   // one write, held for exactly one sampling edge; one more edge lets outputs settle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_wr_o    <= 1'b1;
      reg_addr_o  <= a;
      reg_wdata_o <= d;
      @(posedge clk_i);
      reg_wr_o    <= 1'b0;
      reg_addr_o  <= ~a;  // released lines must not keep the old value
      reg_wdata_o <= ~d;
      @(posedge clk_i);
   endtask

   // one read, data is registered so it is taken one edge later
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      reg_rd_o   <= 1'b1;
      reg_addr_o <= a;
      @(posedge clk_i);
      reg_rd_o   <= 1'b0;
      reg_addr_o <= ~a;
      @(posedge clk_i);
      d = reg_rdata_i;
   endtask

   // no coefficient traffic until the boot bit reads clear over the port
   task automatic wait_boot(output logic ok);
      logic [7:0] d;
      ok = 1'b0;
      for (int i = 0; i < 50 && !ok; i++)
      begin
         rd(8'h65, d);
         ok = (d === 8'h00);
      end
   endtask
endmodule

// File: bench/tb_amp_status_and_fault_regs.sv
`timescale 1ns/1ps
module tb_amp_status_and_fault_regs;
   logic                   clk_i = 1'b0;
   logic                   arst_n_i = 1'b0;
   logic                   reg_wr, reg_rd;
   logic [7:0]             reg_addr, reg_wdata, reg_rdata_o;
   aasf_pkg::aasf_power_t  ps = '0;
   logic                   boot = 1'b0;
   aasf_pkg::aasf_events_t ev = '0;
   logic                   en1 = 1'b0, en2 = 1'b0, mclk1 = 1'b0, mclk2 = 1'b0;
   logic                   run1 = 1'b1, run2 = 1'b1;
   aasf_pkg::aasf_rate_t   pcm_rate_code_o;
   logic                   rec1_o, rec2_o, force_o, power_error_o;
   int                     fail_count = 0;
   int                     cmp_count = 0;

   always #20 clk_i = ~clk_i;
   // monitored clocks stand still while their run flag is low
   always @(posedge clk_i)
   begin
      if (run1) mclk1 <= ~mclk1;
      if (run2) mclk2 <= ~mclk2;
   end

   aasf_host_model host (.clk_i(clk_i), .reg_rdata_i(reg_rdata_o),
      .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));

   // short timeouts: code 0 is 20 cycles, code 7 is 80 cycles
   aasf_regs #(.TIMEOUT_CYC({26'd80, {6{26'd40}}, 26'd20})) uut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .power_state_i(ps),
      .processor_boot_busy_i(boot), .fault_event_i(ev), .det1_enable_i(en1),
      .det2_enable_i(en2), .det1_timeout_i(3'h0), .det2_timeout_i(3'h7),
      .det1_clk_i(mclk1), .det2_clk_i(mclk2), .reg_rdata_o(reg_rdata_o),
      .pcm_rate_code_o(pcm_rate_code_o), .detector_one_recovery_off_o(rec1_o),
      .detector_two_recovery_off_o(rec2_o), .dummy_powerup_force_down_o(force_o),
      .power_error_o(power_error_o));

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      host.rd(a, d);
      chk($sformatf("rdata at %h", a), e, d);
   endtask

   // wait for the power error level, counting cycles, bounded
   task automatic wait_err(input logic v, input int lim, output int n);
      n = 0;
      while (power_error_o !== v && n < lim)
      begin
         @(posedge clk_i);
         n++;
      end
   endtask

   task automatic t_reset;
      logic [7:0] adr [6] = '{8'h2f, 8'h32, 8'h35, 8'h64, 8'h65, 8'h68};
      foreach (adr[i]) rchk(adr[i], 8'h00);
      chk("outputs", 8'h00, {2'h0, power_error_o, force_o, rec2_o, rec1_o, pcm_rate_code_o});
   endtask

   task automatic t_control;
      for (int i = 3; i >= 0; i--)
      begin
         host.wr(8'h2f, 8'hfc | i[7:0]);
         chk("pcm rate", i[7:0], {6'h00, pcm_rate_code_o});
      end
      rchk(8'h2f, 8'h00);
      host.wr(8'h2f, 8'hff);
      rchk(8'h2f, 8'h03);
      host.wr(8'h32, 8'hfd);
      chk("recovery", 8'h01, {6'h00, rec2_o, rec1_o});
      host.wr(8'h32, 8'h02);
      chk("recovery", 8'h02, {6'h00, rec2_o, rec1_o});
      rchk(8'h32, 8'h02);
      host.wr(8'h35, 8'hff);
      chk("force down", 8'h01, {7'h00, force_o});
      rchk(8'h35, 8'h04);
      host.wr(8'h35, 8'hfb);
      chk("force down", 8'h00, {7'h00, force_o});
      host.wr(8'h32, 8'h00);
   endtask

   task automatic t_status;
      logic ok;
      @(posedge clk_i);
      ps <= 6'h2a;
      rchk(8'h64, 8'ha8);
      ps <= 6'h15;
      host.wr(8'h64, 8'hff);
      rchk(8'h64, 8'h54);
      boot <= 1'b1;
      host.wr(8'h65, 8'h00);
      rchk(8'h65, 8'h04);
      rchk(8'h10, 8'h00);
      fork
         begin
            repeat (10) @(posedge clk_i);
            boot <= 1'b0;
         end
         host.wait_boot(ok);
      join
      chk("boot done", 8'h01, {7'h00, ok});
      rchk(8'h65, 8'h00);
   endtask

   task automatic t_faults;
      logic [7:0] bitv [5] = '{8'h80, 8'h40, 8'h10, 8'h08, 8'h02};
      for (int i = 0; i < 5; i++)
      begin
         @(posedge clk_i);
         ev <= 5'h10 >> i;
         @(posedge clk_i);
         ev <= 5'h00;
         rchk(8'h68, bitv[i]);
         rchk(8'h68, 8'h00);
      end
      @(posedge clk_i);
      ev <= 5'h1f;
      @(posedge clk_i);
      ev <= 5'h01;
      host.wr(8'h68, 8'h00);
      rchk(8'h68, 8'hda);
      ev <= 5'h00;
      rchk(8'h68, 8'h02);
      rchk(8'h68, 8'h00);
   endtask

   task automatic t_clk_err;
      int n;
      @(posedge clk_i);
      en1 <= 1'b1;
      repeat (60) @(posedge clk_i);
      chk("error while clocked", 8'h00, {7'h00, power_error_o});
      run1 <= 1'b0;
      wait_err(1'b1, 100, n);
      chk("error delay ok", 8'h01, {7'h00, n >= 20 && n <= 40});
      rchk(8'h68, 8'h04);
      run1 <= 1'b1;
      wait_err(1'b0, 30, n);
      chk("auto recovery", 8'h00, {7'h00, power_error_o});
      host.wr(8'h32, 8'h01);
      run1 <= 1'b0;
      wait_err(1'b1, 100, n);
      run1 <= 1'b1;
      repeat (40) @(posedge clk_i);
      chk("recovery off", 8'h01, {7'h00, power_error_o});
      en1 <= 1'b0;
      wait_err(1'b0, 10, n);
      chk("disabled", 8'h00, {7'h00, power_error_o});
      rchk(8'h68, 8'h04);
      run2 <= 1'b0;
      en2 <= 1'b1;
      wait_err(1'b1, 200, n);
      chk("long delay ok", 8'h01, {7'h00, n >= 80 && n <= 100});
      en2 <= 1'b0;
   endtask

   initial
   begin
      #(40 * 20000);
      fail_count++;
      close_out();
   end

   initial
   begin
      repeat (10) @(posedge clk_i);
      arst_n_i <= 1'b1;
      t_reset();
      t_control();
      t_status();
      t_faults();
      t_clk_err();
      // mid-run reset must bring back every reset value
      @(posedge clk_i);
      arst_n_i <= 1'b0;
      ps       <= '0;
      repeat (2) @(posedge clk_i);
      arst_n_i <= 1'b1;
      t_reset();
      close_out();
   end
endmodule
